// File: hw/cascade_timer_pkg.sv
package cascade_timer_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_T0_LOW = 8'h00;
	localparam logic [7:0] OFF_T1_LOW = 8'h04;
	localparam logic [7:0] OFF_T2_LOW = 8'h08;
	localparam logic [7:0] OFF_T0_HIGH = 8'h10;
	localparam logic [7:0] OFF_T1_HIGH = 8'h14;
	localparam logic [7:0] OFF_T2_HIGH = 8'h18;
	localparam logic [7:0] OFF_T2_MODE = 8'h20;
	localparam logic [7:0] OFF_TIMER_TWO_PRESCALER = 8'h24;
	localparam logic [7:0] OFF_CTRL = 8'h28;
	localparam logic [7:0] OFF_POWER = 8'h2c;
	localparam logic [7:0] OFF_T0_COUNT = 8'h30;
	localparam logic [7:0] OFF_T1_COUNT = 8'h34;
	localparam logic [7:0] OFF_T2_COUNT = 8'h38;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MODE_RUN_BIT = 0;
	localparam int MODE_LOAD_BIT = 1;
	localparam int MODE_COUNT_MODE_BIT = 2;
	localparam int MODE_IRQ_EN_BIT = 3;
	localparam int MODE_OUT_EN_BIT = 4;
	localparam int MODE_EOC_BIT = 7;
	localparam int PRE_CASCADE_LSB = 0;
	localparam int PRE_DIV_LSB = 2;
	localparam int CTRL_T0_RUN_BIT = 0;
	localparam int CTRL_T0_LEN16_BIT = 1;
	localparam int CTRL_T1_RUN_BIT = 2;
	localparam int CTRL_T1_LEN16_BIT = 3;
	localparam int CTRL_T0_LOAD_BIT = 4;
	localparam int CTRL_T1_LOAD_BIT = 5;

	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [7:0] RESET_PRESCALER = 8'h00;
	localparam logic [7:0] RESET_CTRL = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] CASCADE_32 = 2'h0;
	localparam logic [1:0] CASCADE_24 = 2'h1;
	localparam logic [1:0] CASCADE_T1_24 = 2'h2;
	localparam logic [1:0] CASCADE_16 = 2'h3;
	localparam logic [7:0] OP_NO_OPERATION = 8'hff;
	localparam logic [7:0] OP_OSC_OFF_SLEEP = 8'h6f;
	localparam logic [7:0] OP_CLOCK_GATED_SLEEP = 8'h7f;
	localparam logic [15:0] RESTART_ADDR = 16'h000c;

	typedef enum {power_run, power_halt, power_stop} power_e;

	typedef struct packed {
		logic data_strobe_n;
		logic address_strobe_n;
		logic read_write;
	} bus_strobes_s;

	localparam bus_strobes_s STROBES_IDLE = 3'h7;

endpackage

// File: hw/cascade_timers.sv
`timescale 1ns/1ps
// How it works
// RULE_01 - timer zero: low byte, or both bytes
// RULE_02 - timer one: low byte, or own high above
// RULE_03 - timer one 24-bit: t0 high, t1 high, t1 low
// RULE_04 - timer two: 16, 24 or 32 bit chains
// RULE_05 - timer two irq ORed with external pin
// RULE_06 - end of count sets mode bit 7
// RULE_07 - only software clears end of count flag
// RULE_08 - at zero: modulo reloads, single pass halts
// RULE_09 - mode change acts at next zero
// RULE_10 - high bytes mirror low bytes, other bank
// RULE_11 - prescaler bits 1..0 pick cascade
// RULE_12 - clock-gated sleep keeps timers, irqs, oscillator
// RULE_13 - any interrupt ends clock-gated sleep
// RULE_14 - sleep drives strobes high, others hold
// RULE_15 - oscillator-off sleep ends only by reset
// RULE_16 - no-operation must precede a sleep opcode
// RULE_17 - reset: 8-bit timers, t2 32-bit, disabled
// RULE_18 - timer two output routed to pin
// RULE_19 - timer two behaves like timer zero; t2 alone counts on prescaler ticks and has a single pass mode
// RULE_20 - borrow ripples through chain same tick
// RULE_21 - end of count once per pass
module cascade_timers #(
	parameter int PRE_W = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_irq_pin,
	input wire logic [2:0] other_irq_pins,
	input wire cascade_timer_pkg::bus_strobes_s core_strobes,
	output cascade_timer_pkg::bus_strobes_s pin_strobes,
	output logic timer_two_output_pin,
	output logic interrupt_request_zero,
	output logic cpu_clk_en,
	output logic osc_en,
	output logic [15:0] restart_addr
);

	if (PRE_W < 1 || PRE_W > 6) begin : g_bad_pre
		$error("PRE_W must lie in 1..6");
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// one tick of a chained down counter; the whole chain is one
	// binary value so a borrow crosses bytes in the same tick
	function automatic logic [31:0] step(input logic [31:0] c,
		input logic [31:0] rl, input logic modulo);
		if (c == 32'h0)
			step = modulo ? rl : 32'h0;
		else
			step = c - 32'h1;
	endfunction

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready & pwrite;
	wire hit_t0l = paddr == cascade_timer_pkg::OFF_T0_LOW;
	wire hit_t1l = paddr == cascade_timer_pkg::OFF_T1_LOW;
	wire hit_t2l = paddr == cascade_timer_pkg::OFF_T2_LOW;
	wire hit_t0h = paddr == cascade_timer_pkg::OFF_T0_HIGH;
	wire hit_t1h = paddr == cascade_timer_pkg::OFF_T1_HIGH;
	wire hit_t2h = paddr == cascade_timer_pkg::OFF_T2_HIGH;
	wire hit_mode = paddr == cascade_timer_pkg::OFF_T2_MODE;
	wire hit_pre = paddr == cascade_timer_pkg::OFF_TIMER_TWO_PRESCALER;
	wire hit_ctrl = paddr == cascade_timer_pkg::OFF_CTRL;
	wire hit_power = paddr == cascade_timer_pkg::OFF_POWER;
	wire hit_c0 = paddr == cascade_timer_pkg::OFF_T0_COUNT;
	wire hit_c1 = paddr == cascade_timer_pkg::OFF_T1_COUNT;
	wire hit_c2 = paddr == cascade_timer_pkg::OFF_T2_COUNT;
	wire mapped = hit_t0l | hit_t1l | hit_t2l | hit_t0h | hit_t1h |
		hit_t2h | hit_mode | hit_pre | hit_ctrl | hit_power |
		hit_c0 | hit_c1 | hit_c2;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] lo0, hi0, lo1, hi1, lo2, hi2;
	logic [7:0] prescaler, ctrl;
	logic [2:0] mode_cfg;
	logic run2, eoc_flag, prev_nop;
	logic [31:0] cnt0, cnt1, cnt2;
	logic [PRE_W-1:0] pre2;
	logic [2:0] ext_meta, ext_s;
	logic ext0_meta, ext0_s;
	cascade_timer_pkg::power_e state, next_state;

	// high bank at +0x10 mirrors the low bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo0 <= cascade_timer_pkg::RESET_BYTE;
			hi0 <= cascade_timer_pkg::RESET_BYTE;
			lo1 <= cascade_timer_pkg::RESET_BYTE;
			hi1 <= cascade_timer_pkg::RESET_BYTE;
			lo2 <= cascade_timer_pkg::RESET_BYTE;
			hi2 <= cascade_timer_pkg::RESET_BYTE;
		end else if (wr) begin
			if (hit_t0l) lo0 <= pwdata[7:0]; // RULE_10
			if (hit_t0h) hi0 <= pwdata[7:0]; // RULE_10
			if (hit_t1l) lo1 <= pwdata[7:0];
			if (hit_t1h) hi1 <= pwdata[7:0]; // RULE_10
			if (hit_t2l) lo2 <= pwdata[7:0];
			if (hit_t2h) hi2 <= pwdata[7:0];
		end
	end

	// power-up: cascade 32-bit, t0/t1 8-bit, irq and pin off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler <= cascade_timer_pkg::RESET_PRESCALER; // RULE_17
			ctrl <= cascade_timer_pkg::RESET_CTRL; // RULE_17
			mode_cfg <= cascade_timer_pkg::RESET_MODE[4:2]; // RULE_17
		end else if (wr) begin
			if (hit_pre) prescaler <= pwdata[7:0];
			if (hit_ctrl) ctrl <= pwdata[7:0];
			if (hit_mode) mode_cfg <= pwdata[4:2];
		end
	end

	// ------------------------------------------------------------
	// cascade selection
	// ------------------------------------------------------------
	wire [1:0] casc = prescaler[1:0]; // RULE_11
	wire count_mode = mode_cfg[0];
	wire irq_en = mode_cfg[1];
	wire out_en = mode_cfg[2];
	// timer zero's high byte is free only when timer two stays 16-bit
	wire len0_16 = ctrl[cascade_timer_pkg::CTRL_T0_LEN16_BIT] &
		(casc == cascade_timer_pkg::CASCADE_16);
	wire t1_24 = casc == cascade_timer_pkg::CASCADE_T1_24;
	wire len1_16 = ctrl[cascade_timer_pkg::CTRL_T1_LEN16_BIT] &
		(casc == cascade_timer_pkg::CASCADE_24 |
		casc == cascade_timer_pkg::CASCADE_16);
	wire [31:0] rl0 = len0_16 ? {16'h0, hi0, lo0} : {24'h0, lo0}; // RULE_01
	wire [31:0] rl1 = t1_24 ? {8'h0, hi0, hi1, lo1} : // RULE_03
		len1_16 ? {16'h0, hi1, lo1} : {24'h0, lo1}; // RULE_02
	wire [31:0] rl2 = casc == cascade_timer_pkg::CASCADE_32 ? // RULE_04
		{hi0, hi1, hi2, lo2} :
		casc == cascade_timer_pkg::CASCADE_24 ?
		{8'h0, hi0, hi2, lo2} : {16'h0, hi2, lo2};

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	// oscillator off freezes every counter
	wire osc_alive = state != cascade_timer_pkg::power_stop; // RULE_12
	wire tick2 = osc_alive & (pre2 == '0);
	wire load0 = wr & hit_ctrl & pwdata[cascade_timer_pkg::CTRL_T0_LOAD_BIT];
	wire load1 = wr & hit_ctrl & pwdata[cascade_timer_pkg::CTRL_T1_LOAD_BIT];
	wire load2 = wr & hit_mode & pwdata[cascade_timer_pkg::MODE_LOAD_BIT];
	wire run0 = ctrl[cascade_timer_pkg::CTRL_T0_RUN_BIT] & osc_alive;
	wire run1 = ctrl[cascade_timer_pkg::CTRL_T1_RUN_BIT] & osc_alive;
	// zero seen on a tick is one end of count; modulo reloads, single pass clears run2
	wire eoc2 = run2 & tick2 & (cnt2 == 32'h0); // RULE_21
	wire clear_flag = wr & hit_mode & ~pwdata[cascade_timer_pkg::MODE_EOC_BIT];
	wire irq_level = eoc_flag & irq_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pre2 <= '0;
		else if (osc_alive)
			pre2 <= tick2 ? prescaler[PRE_W+1:2] : pre2 - 1'b1; // RULE_19
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt0 <= 32'h0;
			cnt1 <= 32'h0;
		end else begin
			if (load0) cnt0 <= rl0;
			else if (run0) cnt0 <= step(cnt0, rl0, 1'b1); // RULE_20
			if (load1) cnt1 <= rl1;
			else if (run1) cnt1 <= step(cnt1, rl1, 1'b1); // RULE_20
		end
	end

	// count mode is only looked at when the chain reaches zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt2 <= 32'h0;
		else if (load2)
			cnt2 <= rl2;
		else if (run2 & tick2)
			cnt2 <= step(cnt2, rl2, count_mode); // RULE_08 RULE_09 RULE_20
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run2 <= 1'b0;
		else if (wr & hit_mode)
			run2 <= pwdata[cascade_timer_pkg::MODE_RUN_BIT];
		else if (eoc2 & ~count_mode)
			run2 <= 1'b0; // RULE_08
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			eoc_flag <= 1'b0;
		else if (eoc2)
			eoc_flag <= 1'b1; // RULE_06
		else if (clear_flag)
			eoc_flag <= 1'b0; // RULE_07
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_two_output_pin <= 1'b0;
		else if (!out_en)
			timer_two_output_pin <= 1'b0;
		else if (eoc2)
			timer_two_output_pin <= ~timer_two_output_pin; // RULE_18
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext0_meta <= 1'b0;
			ext0_s <= 1'b0;
			ext_meta <= 3'h0;
			ext_s <= 3'h0;
		end else begin
			ext0_meta <= external_irq_pin;
			ext0_s <= ext0_meta;
			ext_meta <= other_irq_pins;
			ext_s <= ext_meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			interrupt_request_zero <= 1'b0;
		else
			interrupt_request_zero <= irq_level | ext0_s; // RULE_05
	end

	// ------------------------------------------------------------
	// sleep control
	// ------------------------------------------------------------
	wire [7:0] op = pwdata[7:0];
	wire op_wr = wr & hit_power;
	wire wake = irq_level | ext0_s | (|ext_s); // RULE_12
	// a sleep opcode without the flush before it is ignored
	wire enter_halt = op_wr & prev_nop &
		(op == cascade_timer_pkg::OP_CLOCK_GATED_SLEEP); // RULE_16
	wire enter_stop = op_wr & prev_nop &
		(op == cascade_timer_pkg::OP_OSC_OFF_SLEEP); // RULE_16

	always_comb begin
		next_state = state;
		case (state)
			cascade_timer_pkg::power_run: begin
				if (enter_stop)
					next_state = cascade_timer_pkg::power_stop;
				else if (enter_halt)
					next_state = cascade_timer_pkg::power_halt;
			end
			cascade_timer_pkg::power_halt: begin
				if (wake)
					next_state = cascade_timer_pkg::power_run; // RULE_13
			end
			cascade_timer_pkg::power_stop: begin
				next_state = cascade_timer_pkg::power_stop; // RULE_15
			end
			default: next_state = cascade_timer_pkg::power_run;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= cascade_timer_pkg::power_run;
			prev_nop <= 1'b0;
		end else begin
			state <= next_state;
			if (op_wr)
				prev_nop <= op == cascade_timer_pkg::OP_NO_OPERATION;
		end
	end

	// strobes parked high asleep; everything else just holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_strobes <= cascade_timer_pkg::STROBES_IDLE;
			cpu_clk_en <= 1'b1;
			osc_en <= 1'b1;
			restart_addr <= cascade_timer_pkg::RESTART_ADDR; // RULE_15
		end else begin
			pin_strobes <= next_state == cascade_timer_pkg::power_run ?
				core_strobes : cascade_timer_pkg::STROBES_IDLE; // RULE_14
			cpu_clk_en <= next_state == cascade_timer_pkg::power_run;
			osc_en <= next_state != cascade_timer_pkg::power_stop; // RULE_15
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (1'b1)
			hit_t0l: rd_mux = {24'h0, lo0};
			hit_t1l: rd_mux = {24'h0, lo1};
			hit_t2l: rd_mux = {24'h0, lo2};
			hit_t0h: rd_mux = {24'h0, hi0};
			hit_t1h: rd_mux = {24'h0, hi1};
			hit_t2h: rd_mux = {24'h0, hi2};
			hit_mode: rd_mux = {24'h0, eoc_flag, 2'h0, mode_cfg, 1'b0, run2};
			hit_pre: rd_mux = {24'h0, prescaler};
			hit_ctrl: rd_mux = {24'h0, 2'h0, ctrl[5:0] & 6'h0f};
			hit_power: rd_mux = {30'h0, osc_en, cpu_clk_en};
			hit_c0: rd_mux = cnt0;
			hit_c1: rd_mux = cnt1;
			hit_c2: rd_mux = cnt2;
			default: rd_mux = 32'h0;
		endcase
	end

	// answer prepared in setup, given in one access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			if (setup)
				prdata <= pwrite ? 32'h0 : rd_mux;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_t0_len16;
		load0 && len0_16 |=> cnt0 == {16'h0, $past(hi0), $past(lo0)};
	endproperty
	a_t0_len16: assert property (p_t0_len16) else $error("t0 16-bit load"); // RULE_01

	property p_t2_len32;
		load2 && casc == cascade_timer_pkg::CASCADE_32 |=>
			cnt2 == {$past(hi0), $past(hi1), $past(hi2), $past(lo2)};
	endproperty
	a_t2_len32: assert property (p_t2_len32) else $error("t2 32-bit load"); // RULE_04

	property p_chain_dec;
		run2 && tick2 && !load2 && cnt2 != 32'h0 |=> cnt2 == $past(cnt2) - 32'h1;
	endproperty
	a_chain_dec: assert property (p_chain_dec) else $error("chain borrow"); // RULE_20

	property p_eoc_sets;
		eoc2 |=> eoc_flag ##1 interrupt_request_zero || !$past(irq_en);
	endproperty
	a_eoc_sets: assert property (p_eoc_sets) else $error("eoc flag not set"); // RULE_06

	property p_flag_sticky;
		eoc_flag && !clear_flag |=> eoc_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost"); // RULE_07

	property p_single_halts;
		eoc2 && !count_mode && !(wr && hit_mode) && !load2 |=>
			!run2 && cnt2 == 32'h0;
	endproperty
	a_single_halts: assert property (p_single_halts) else $error("no halt"); // RULE_08

	property p_ext_irq;
		ext0_s |=> interrupt_request_zero;
	endproperty
	a_ext_irq: assert property (p_ext_irq) else $error("interrupt_request_zero missed pin"); // RULE_05

	property p_halt_strobes;
		state == cascade_timer_pkg::power_halt && !wake |=>
			pin_strobes == cascade_timer_pkg::STROBES_IDLE && !cpu_clk_en && osc_en;
	endproperty
	a_halt_strobes: assert property (p_halt_strobes) else $error("halt pins"); // RULE_14

	property p_halt_wake;
		state == cascade_timer_pkg::power_halt && wake |=> cpu_clk_en;
	endproperty
	a_halt_wake: assert property (p_halt_wake) else $error("no wake"); // RULE_13

	property p_stop_holds;
		state == cascade_timer_pkg::power_stop |=> !osc_en [*2];
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stop left"); // RULE_15

	c_modulo: cover property (eoc2 && count_mode ##1 run2);
	c_halt_wake: cover property (
		state == cascade_timer_pkg::power_halt ##1 cpu_clk_en);
	c_stop: cover property (enter_stop);
	c_t1_24: cover property (load1 && t1_24);

endmodule // cascade_timers

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic external_irq_pin;
	logic [2:0] other_irq_pins;
	cascade_timer_pkg::bus_strobes_s core_strobes;
	cascade_timer_pkg::bus_strobes_s pin_strobes;
	logic timer_two_output_pin;
	logic interrupt_request_zero;
	logic cpu_clk_en;
	logic osc_en;
	logic [15:0] restart_addr;
	int failures;
	int checked;
	int seed;
	logic last_err;
	logic [31:0] rd;
	logic [31:0] rd2;
	logic [7:0] b [0:5];
	int n;

	cascade_timers #(.PRE_W(6)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.external_irq_pin(external_irq_pin),
		.other_irq_pins(other_irq_pins), .core_strobes(core_strobes),
		.pin_strobes(pin_strobes),
		.timer_two_output_pin(timer_two_output_pin),
		.interrupt_request_zero(interrupt_request_zero),
		.cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
		.restart_addr(restart_addr)
	);

	// ------------------------------------------------------------
	// clock, watchdog and closing
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	initial begin
		#(20000 * 100);
		failures++;
		stop_test();
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ------------------------------------------------------------
	// apb master
	// ------------------------------------------------------------
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no latency assumed; only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	// expected count readbacks for a cascade code
	function automatic logic [31:0] exp_t2(logic [1:0] c);
		case (c)
			2'h0: exp_t2 = {b[3], b[4], b[5], b[2]};
			2'h1: exp_t2 = {8'h00, b[3], b[5], b[2]};
			default: exp_t2 = {16'h0, b[5], b[2]};
		endcase
	endfunction

	function automatic logic [31:0] exp_t1(logic [1:0] c);
		case (c)
			2'h2: exp_t1 = {8'h00, b[3], b[4], b[1]};
			2'h0: exp_t1 = {24'h0, b[1]};
			default: exp_t1 = {16'h0, b[4], b[1]};
		endcase
	endfunction

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		seed = 8472;
		failures = 0;
		checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		external_irq_pin = 1'b0;
		other_irq_pins = 3'h0;
		core_strobes = 3'h0;
		do_reset();

		apb(1'b0, 8'h20, 32'h0);
		check("mode reset", 32'h0, rd);
		apb(1'b0, 8'h24, 32'h0);
		check("prescaler reset", 32'h0, rd);
		apb(1'b0, 8'h2c, 32'h0);
		check("power reset", 32'h3, rd);
		check("restart addr", 32'h000c, {16'h0, restart_addr});
		apb(1'b0, 8'hfc, 32'h0);
		check("unmapped err", 32'h1, {31'h0, last_err});
		$display("test reset done");

		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 6; k++) begin
				b[k] = 8'($random(seed));
				wr(8'((k / 3) * 16 + (k % 3) * 4), b[k]);
			end
			wr(8'h24, 8'(c));
			wr(8'h28, 8'h3a);
			wr(8'h20, 8'h02);
			apb(1'b0, 8'h30, 32'h0);
			check("t0 count", (c == 3) ? {16'h0, b[3], b[0]} : {24'h0, b[0]},
				rd);
			apb(1'b0, 8'h34, 32'h0);
			check("t1 count", exp_t1(2'(c)), rd);
			apb(1'b0, 8'h38, 32'h0);
			check("t2 count", exp_t2(2'(c)), rd);
		end
		$display("test cascade done");

		wr(8'h28, 8'h00);
		wr(8'h24, 8'h03);
		wr(8'h08, 8'h03);
		wr(8'h18, 8'h00);
		wr(8'h20, 8'h1b);
		for (n = 0; n < 60 && interrupt_request_zero !== 1'b1; n++) begin
			@(posedge pclk);
		end
		check("interrupt_request_zero on eoc", 32'h1, {31'h0, interrupt_request_zero});
		repeat (20) @(posedge pclk);
		apb(1'b0, 8'h20, 32'h0);
		check("single pass halt", 32'h98, rd);
		apb(1'b0, 8'h38, 32'h0);
		check("halted count", 32'h0, rd);
		check("t2 pin", 32'h1, {31'h0, timer_two_output_pin});
		wr(8'h20, 8'h10);
		repeat (3) @(posedge pclk);
		check("flag cleared", 32'h0, {31'h0, interrupt_request_zero});
		apb(1'b0, 8'h20, 32'h0);
		check("flag readback", 32'h10, rd);
		$display("test single pass done");

		wr(8'h08, 8'h20);
		wr(8'h20, 8'h0f);
		for (n = 0; n < 100 && interrupt_request_zero !== 1'b1; n++) begin
			@(posedge pclk);
		end
		wr(8'h20, 8'h0d);
		for (n = 0; n < 20 && interrupt_request_zero !== 1'b0; n++) begin
			@(posedge pclk);
		end
		check("irq dropped", 32'h0, {31'h0, interrupt_request_zero});
		check("t2 pin off", 32'h0, {31'h0, timer_two_output_pin});
		for (n = 0; n < 100 && interrupt_request_zero !== 1'b1; n++) begin
			@(posedge pclk);
		end
		check("modulo again", 32'h1, {31'h0, interrupt_request_zero});
		// single pass asked mid-count: run stays until the next zero
		wr(8'h20, 8'h09);
		apb(1'b0, 8'h20, 32'h0);
		check("mode change waits", 32'h09, rd);
		repeat (2) @(posedge pclk);
		for (n = 0; n < 100 && interrupt_request_zero !== 1'b1; n++) begin
			@(posedge pclk);
		end
		apb(1'b0, 8'h20, 32'h0);
		check("halt at next zero", 32'h88, rd);
		wr(8'h20, 8'h00);
		$display("test modulo done");

		external_irq_pin <= 1'b1;
		repeat (5) @(posedge pclk);
		check("pin to interrupt_request_zero", 32'h1, {31'h0, interrupt_request_zero});
		external_irq_pin <= 1'b0;
		repeat (5) @(posedge pclk);
		check("pin released", 32'h0, {31'h0, interrupt_request_zero});
		$display("test irq pin done");

		wr(8'h00, 8'hff);
		wr(8'h28, 8'h11);
		wr(8'h2c, 8'h7f);
		check("sleep needs nop", 32'h1, {31'h0, cpu_clk_en});
		wr(8'h2c, 8'hff);
		wr(8'h2c, 8'h7f);
		core_strobes <= 3'($random(seed));
		repeat (2) @(posedge pclk);
		check("cpu clock off", 32'h0, {31'h0, cpu_clk_en});
		check("osc kept", 32'h1, {31'h0, osc_en});
		check("strobes high", 32'h7, {29'h0, pin_strobes});
		apb(1'b0, 8'h30, 32'h0);
		rd2 = rd;
		apb(1'b0, 8'h30, 32'h0);
		check("timer runs asleep", 32'h1, {31'h0, rd != rd2});
		other_irq_pins <= 3'h2;
		for (n = 0; n < 10 && cpu_clk_en !== 1'b1; n++) begin
			@(posedge pclk);
		end
		check("wake on irq", 32'h1, {31'h0, cpu_clk_en});
		other_irq_pins <= 3'h0;
		core_strobes <= 3'h2;
		repeat (3) @(posedge pclk);
		check("strobes follow", 32'h2, {29'h0, pin_strobes});
		$display("test clock gated done");

		wr(8'h2c, 8'hff);
		wr(8'h2c, 8'h6f);
		external_irq_pin <= 1'b1;
		repeat (10) @(posedge pclk);
		check("osc off", 32'h0, {30'h0, osc_en, cpu_clk_en});
		apb(1'b0, 8'h30, 32'h0);
		rd2 = rd;
		apb(1'b0, 8'h30, 32'h0);
		check("count frozen", 32'h1, {31'h0, rd == rd2});
		external_irq_pin <= 1'b0;
		do_reset();
		check("reset wakes", 32'h3, {30'h0, osc_en, cpu_clk_en});
		check("restart addr", 32'h000c, {16'h0, restart_addr});
		$display("test oscillator off done");
		stop_test();
	end
endmodule // tb
